// ### common/acs_pkg.sv
package acs_pkg;
  localparam int IDX_W = 16;
  localparam int DAT_W = 32;
  localparam int ACT_N = 4;
  // Object dictionary indices
  localparam logic [15:0] IDX_SYNC_ROLE = 16'h2012;
  localparam logic [15:0] IDX_PARAM_MATCH = 16'h2013;
  localparam logic [15:0] IDX_CTRL_ONE = 16'h2268;
  localparam logic [15:0] IDX_CTRL_ONE_MASK = 16'h2269;
  localparam logic [15:0] IDX_CTRL_TWO = 16'h226A;
  localparam logic [15:0] IDX_CTRL_TWO_MASK = 16'h226B;
  localparam logic [15:0] IDX_CAL_TRIG = 16'h6111;
  localparam logic [15:0] IDX_ZERO_TRIG = 16'h6125;
  localparam logic [15:0] IDX_TARE_TRIG = 16'h6139;
  localparam logic [15:0] IDX_MEAS_STATUS = 16'h6150;
  localparam logic [15:0] IDX_PROF_CTRL = 16'h6160;
  localparam logic [15:0] IDX_PROF_MASK = 16'h6161;
  localparam logic [15:0] IDX_LIFE_CNT = 16'h6F20;
  // Trigger constants
  localparam logic [31:0] MAGIC_CAL = 32'h696C6163;
  localparam logic [31:0] MAGIC_ZERO = 32'h7A65726F;
  localparam logic [31:0] MAGIC_TARE = 32'h74617261;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  // First control byte fields
  localparam int C1_ZERO = 0;
  localparam int C1_TARE = 1;
  localparam int C1_CONT = 2;
  localparam int C1_ONCE = 4;
  localparam int C1_STOP = 6;
  localparam logic [7:0] C1_EDGE_BITS = 8'h33;
  localparam logic [7:0] C1_SAVED_BITS = 8'hCC;
  // Second control byte and profile byte fields
  localparam int C2_CAL = 0;
  localparam int C2_ZERO = 1;
  localparam int C2_TARE = 2;
  localparam int C2_SHEET = 7;
  localparam int PR_CAL = 0;
  localparam int PR_ZERO = 1;
  localparam int PR_TARE = 2;
  // Status byte fields
  localparam int ST_INVALID = 0;
  localparam int ST_POS = 1;
  localparam int ST_NEG = 2;
  // Action slots, lowest index runs first
  localparam int ACT_ZERO = 0;
  localparam int ACT_TARE = 1;
  localparam int ACT_CAL = 2;
  localparam int ACT_SHEET = 3;
  typedef enum logic [1:0] {
    CODE_ZERO = 2'h0,
    CODE_TARE = 2'h1,
    CODE_CAL = 2'h2,
    CODE_SHEET = 2'h3
  } acs_code_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_START = 2'h1,
    SEQ_WAIT = 2'h3
  } acs_seq_t;
endpackage : acs_pkg

// ### common/acs_req_if.sv
`timescale 1ns/10ps
// Action requests from the object logic to the sequencer
interface acs_req_if;
  import acs_pkg::*;
  logic [ACT_N-1:0] req;
  logic done;
  logic busy;
  logic start;
  acs_code_t code;
  modport cmd (output req, output done, input busy, input start, input code);
  modport seq (input req, input done, output busy, output start, output code);
endinterface : acs_req_if

// ### rtl/acs_sequencer.sv
`timescale 1ns/10ps
module acs_sequencer (
  input wire logic clk,
  input wire logic rst_b,
  acs_req_if.seq bus
);
  import acs_pkg::*;

  logic [ACT_N-1:0] pend;
  logic [ACT_N-1:0] grant;
  acs_seq_t state;
  acs_code_t sel;

  // ----------------------------------------
  // Priority pick
  // ----------------------------------------
  // Zeroing before taring before calibration; sheet calibration last
  always_comb begin
    if (pend[ACT_ZERO]) begin
      sel = CODE_ZERO;
    end else if (pend[ACT_TARE]) begin
      sel = CODE_TARE;
    end else if (pend[ACT_CAL]) begin
      sel = CODE_CAL;
    end else begin
      sel = CODE_SHEET; // Alone by contract of the master
    end
  end

  // Pending bit retired when its start pulse goes out
  always_comb begin
    grant = '0;
    if (state == SEQ_START) begin
      grant[bus.code] = 1'b1;
    end
  end

  // Pending requests, a new request wins over retirement
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~grant) | bus.req;
    end
  end

  // Issue one action and wait for its completion
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= SEQ_IDLE;
      bus.code <= CODE_ZERO;
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (|pend) begin
            bus.code <= sel;
            state <= SEQ_START;
          end
        end
        SEQ_START: state <= SEQ_WAIT;
        SEQ_WAIT: begin
          if (bus.done) begin
            state <= SEQ_IDLE;
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  assign bus.start = (state == SEQ_START);
  assign bus.busy = (state != SEQ_IDLE) || (|pend);
endmodule : acs_sequencer

// ### rtl/acs_top.sv
`timescale 1ns/10ps
module acs_top (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Object dictionary access from the protocol engine
  input wire logic [acs_pkg::IDX_W-1:0] OBJ_INDEX,
  input wire logic OBJ_WR,
  input wire logic OBJ_RD,
  input wire logic [acs_pkg::DAT_W-1:0] OBJ_WDATA,
  output logic [acs_pkg::DAT_W-1:0] OBJ_RDATA,
  output logic OBJ_ACK,
  output logic OBJ_ERR,
  // Measurement condition inputs from the amplifier core
  input wire logic OVERLOAD_POS,
  input wire logic OVERLOAD_NEG,
  input wire logic GROSS_ABOVE_LIMIT,
  input wire logic GROSS_BELOW_LIMIT,
  input wire logic WIRING_FAULT,
  input wire logic EXCITATION_UNDEF,
  input wire logic SCALING_ERR,
  input wire logic SHEET_ALWAYS_USE,
  input wire logic SHEET_PRESENT,
  input wire logic PARAMS_DIFFER,
  input wire logic SYNC_MASTER_PIN,
  // Action handshake to the amplifier core
  input wire logic ACTION_DONE,
  output logic ACTION_START,
  output acs_pkg::acs_code_t ACTION_CODE,
  // Peak memory control, bit 0 max, bit 1 min
  output logic [1:0] PEAK_FOLLOW,
  output logic [1:0] PEAK_CLEAR,
  output logic [1:0] PEAK_HOLD,
  // Part of the first control byte kept in the parameter set
  output logic [7:0] SAVED_CTRL_ONE
);
  import acs_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  acs_req_if req_bus ();

  logic [7:0] ctrl_one;
  logic [7:0] ctrl_one_mask;
  logic [7:0] ctrl_two;
  logic [7:0] ctrl_two_mask;
  logic [7:0] prof_ctrl;
  logic [7:0] prof_mask;
  logic [7:0] eff_one;
  logic [7:0] eff_two;
  logic [7:0] eff_prof;
  logic [7:0] prev_one;
  logic [7:0] prev_two;
  logic [7:0] prev_prof;
  logic [7:0] rise_one;
  logic [7:0] rise_two;
  logic [7:0] rise_prof;
  logic [7:0] meas_status;
  logic [7:0] life_count;
  logic param_differ;
  logic sync_s1;
  logic sync_s2;
  logic sync_s3;
  logic sync_master;
  logic [1:0] once_pend;
  logic [1:0] once_fire;
  logic [7:0] once_done_bits;
  logic wr_hit_ctrl_one;
  logic trig_cal;
  logic trig_zero;
  logic trig_tare;
  logic idx_known;
  logic idx_readable;
  logic idx_writable;
  logic [7:0] rd_byte;
  logic [ACT_N-1:0] next_req;

  // ----------------------------------------
  // Masked commands and edge detection
  // ----------------------------------------
  // A mask bit of 0 makes the command bit look like 0
  assign eff_one = ctrl_one & ctrl_one_mask;
  assign eff_two = ctrl_two & ctrl_two_mask;
  assign eff_prof = prof_ctrl & prof_mask;
  // Rising edges of the gated command bits
  assign rise_one = eff_one & ~prev_one & C1_EDGE_BITS;
  assign rise_two = eff_two & ~prev_two;
  assign rise_prof = eff_prof & ~prev_prof;

  // Previous gated values for edge detection
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      prev_one <= BYTE_RST;
      prev_two <= BYTE_RST;
      prev_prof <= BYTE_RST;
    end else begin
      prev_one <= eff_one;
      prev_two <= eff_two;
      prev_prof <= eff_prof;
    end
  end

  // ----------------------------------------
  // Trigger objects
  // ----------------------------------------
  // Only the exact constant starts an action; others are dropped
  assign trig_cal = OBJ_WR && (OBJ_INDEX == IDX_CAL_TRIG)
                    && (OBJ_WDATA == MAGIC_CAL);
  assign trig_zero = OBJ_WR && (OBJ_INDEX == IDX_ZERO_TRIG)
                     && (OBJ_WDATA == MAGIC_ZERO);
  assign trig_tare = OBJ_WR && (OBJ_INDEX == IDX_TARE_TRIG)
                     && (OBJ_WDATA == MAGIC_TARE);

  // Collect action requests from every source
  always_comb begin
    next_req = '0;
    next_req[ACT_ZERO] = rise_one[C1_ZERO] | rise_two[C2_ZERO] | rise_prof[PR_ZERO]
                         | trig_zero;
    next_req[ACT_TARE] = rise_one[C1_TARE] | rise_two[C2_TARE] | rise_prof[PR_TARE]
                         | trig_tare;
    next_req[ACT_CAL] = rise_two[C2_CAL] | rise_prof[PR_CAL] | trig_cal;
    next_req[ACT_SHEET] = rise_two[C2_SHEET];
  end

  assign req_bus.req = next_req;
  assign req_bus.done = ACTION_DONE;
  assign ACTION_START = req_bus.start;
  assign ACTION_CODE = req_bus.code;

  // ----------------------------------------
  // Action sequencer
  // ----------------------------------------
  acs_sequencer u_seq (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .bus(req_bus.seq)
  );

  // ----------------------------------------
  // Peak-value memory control
  // ----------------------------------------
  // One channel each for max and min peak memory
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_peak
      // Continuous clear outranks one-off clear, which outranks stop
      assign once_fire[ch] = once_pend[ch] && !req_bus.busy
                             && !eff_one[C1_CONT + ch];

      // One-off clear waits until no action is pending or running in the sequencer
      always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
          once_pend[ch] <= 1'b0;
        end else if (rise_one[C1_ONCE + ch]) begin
          once_pend[ch] <= 1'b1;
        end else if (once_fire[ch] || eff_one[C1_CONT + ch]) begin
          once_pend[ch] <= 1'b0;
        end
      end

      // Registered peak memory controls
      always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
          PEAK_FOLLOW[ch] <= 1'b0;
          PEAK_CLEAR[ch] <= 1'b0;
          PEAK_HOLD[ch] <= 1'b0;
        end else begin
          PEAK_FOLLOW[ch] <= eff_one[C1_CONT + ch];
          PEAK_CLEAR[ch] <= once_fire[ch];
          PEAK_HOLD[ch] <= eff_one[C1_STOP + ch] && !eff_one[C1_CONT + ch]
                           && !once_pend[ch];
        end
      end
    end
  endgenerate

  // Clearing a one-off request bit once the clear has been done
  always_comb begin
    once_done_bits = BYTE_RST;
    once_done_bits[C1_ONCE] = once_fire[0];
    once_done_bits[C1_ONCE + 1] = once_fire[1];
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  assign wr_hit_ctrl_one = OBJ_WR && (OBJ_INDEX == IDX_CTRL_ONE);

  // First control byte; a master write wins over self-clearing
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ctrl_one <= BYTE_RST;
    end else if (wr_hit_ctrl_one) begin
      ctrl_one <= OBJ_WDATA[7:0];
    end else begin
      ctrl_one <= ctrl_one & ~once_done_bits;
    end
  end

  // Mask and second and profile control bytes
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ctrl_one_mask <= BYTE_RST;
      ctrl_two <= BYTE_RST;
      ctrl_two_mask <= BYTE_RST;
      prof_ctrl <= BYTE_RST;
      prof_mask <= BYTE_RST;
    end else if (OBJ_WR) begin
      case (OBJ_INDEX)
        IDX_CTRL_ONE_MASK: ctrl_one_mask <= OBJ_WDATA[7:0];
        IDX_CTRL_TWO: ctrl_two <= OBJ_WDATA[7:0];
        IDX_CTRL_TWO_MASK: ctrl_two_mask <= OBJ_WDATA[7:0];
        IDX_PROF_CTRL: prof_ctrl <= OBJ_WDATA[7:0];
        IDX_PROF_MASK: prof_mask <= OBJ_WDATA[7:0];
        default: ;
      endcase
    end
  end

  // Only the persistent bits go to the parameter set
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      SAVED_CTRL_ONE <= BYTE_RST;
    end else begin
      SAVED_CTRL_ONE <= ctrl_one & C1_SAVED_BITS;
    end
  end

  // ----------------------------------------
  // Status objects
  // ----------------------------------------
  // Measured-value status, rebuilt each cycle so bits clear themselves
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      meas_status <= BYTE_RST;
    end else begin
      meas_status <= BYTE_RST;
      // Range limits are left out of the invalid bit
      meas_status[ST_INVALID] <= OVERLOAD_POS | OVERLOAD_NEG | WIRING_FAULT
                                 | EXCITATION_UNDEF | SCALING_ERR
                                 | (SHEET_ALWAYS_USE & ~SHEET_PRESENT);
      meas_status[ST_POS] <= OVERLOAD_POS | GROSS_ABOVE_LIMIT;
      meas_status[ST_NEG] <= OVERLOAD_NEG | GROSS_BELOW_LIMIT;
    end
  end

  // Parameter match flag
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      param_differ <= 1'b0;
    end else begin
      param_differ <= PARAMS_DIFFER;
    end
  end

  // Synchronisation role pin, taken once two stages agree
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
      sync_master <= 1'b0;
    end else begin
      sync_s1 <= SYNC_MASTER_PIN;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      if (sync_s2 == sync_s3) begin
        sync_master <= sync_s3;
      end
    end
  end

  // Life counter advances on each read of its object
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      life_count <= BYTE_RST;
    end else if (OBJ_RD && (OBJ_INDEX == IDX_LIFE_CNT)) begin
      life_count <= life_count + 8'h01;
    end
  end

  // ----------------------------------------
  // Object access answers
  // ----------------------------------------
  // Read multiplexer and access rights per index
  always_comb begin
    rd_byte = BYTE_RST;
    idx_known = 1'b1;
    idx_readable = 1'b1;
    idx_writable = 1'b0;
    case (OBJ_INDEX)
      IDX_SYNC_ROLE: rd_byte = {7'h00, sync_master};
      IDX_PARAM_MATCH: rd_byte = {7'h00, param_differ};
      IDX_CTRL_ONE: begin
        rd_byte = ctrl_one;
        idx_writable = 1'b1;
      end
      IDX_CTRL_ONE_MASK: begin
        rd_byte = ctrl_one_mask;
        idx_writable = 1'b1;
      end
      IDX_CTRL_TWO: begin
        rd_byte = ctrl_two;
        idx_writable = 1'b1;
      end
      IDX_CTRL_TWO_MASK: begin
        rd_byte = ctrl_two_mask;
        idx_writable = 1'b1;
      end
      IDX_PROF_CTRL: begin
        rd_byte = prof_ctrl;
        idx_writable = 1'b1;
      end
      IDX_PROF_MASK: begin
        rd_byte = prof_mask;
        idx_writable = 1'b1;
      end
      IDX_CAL_TRIG, IDX_ZERO_TRIG, IDX_TARE_TRIG: begin
        idx_readable = 1'b0;
        idx_writable = 1'b1;
      end
      IDX_MEAS_STATUS: rd_byte = meas_status;
      IDX_LIFE_CNT: rd_byte = life_count;
      default: begin
        idx_known = 1'b0;
        idx_readable = 1'b0;
      end
    endcase
  end

  // Answer one cycle after each access; refused ones flag an error
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      OBJ_ACK <= 1'b0;
      OBJ_ERR <= 1'b0;
      OBJ_RDATA <= WORD_RST;
    end else begin
      OBJ_ACK <= OBJ_RD | OBJ_WR;
      OBJ_ERR <= (OBJ_RD && !idx_readable) || (OBJ_WR && !idx_writable)
                 || ((OBJ_RD || OBJ_WR) && !idx_known);
      if (OBJ_RD && idx_readable) begin
        OBJ_RDATA <= {24'h000000, rd_byte};
      end else begin
        OBJ_RDATA <= WORD_RST;
      end
    end
  end
endmodule : acs_top

// ### verif/acs_checker.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker for the control and status objects
// ------------------------------------------------------------
module acs_checker (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [acs_pkg::IDX_W-1:0] OBJ_INDEX,
  input wire logic OBJ_WR,
  input wire logic OBJ_RD,
  input wire logic [acs_pkg::DAT_W-1:0] OBJ_WDATA,
  input wire logic [acs_pkg::DAT_W-1:0] OBJ_RDATA,
  input wire logic OBJ_ACK,
  input wire logic OBJ_ERR,
  input wire logic OVERLOAD_POS,
  input wire logic OVERLOAD_NEG,
  input wire logic GROSS_ABOVE_LIMIT,
  input wire logic GROSS_BELOW_LIMIT,
  input wire logic WIRING_FAULT,
  input wire logic EXCITATION_UNDEF,
  input wire logic SCALING_ERR,
  input wire logic SHEET_ALWAYS_USE,
  input wire logic SHEET_PRESENT,
  input wire logic PARAMS_DIFFER,
  input wire logic [1:0] PEAK_FOLLOW,
  input wire logic [1:0] PEAK_CLEAR,
  input wire logic [1:0] PEAK_HOLD,
  input wire logic [7:0] SAVED_CTRL_ONE
);
  import acs_pkg::*;
  logic inv;
  logic rd_st;
  logic [7:0] last_c1;
  // Expected invalid flag and status read strobe
  assign inv = OVERLOAD_POS | OVERLOAD_NEG | WIRING_FAULT | EXCITATION_UNDEF | SCALING_ERR
    | (SHEET_ALWAYS_USE & ~SHEET_PRESENT);
  assign rd_st = OBJ_RD && (OBJ_INDEX == IDX_MEAS_STATUS);
  // Kept part of the last first-control-byte write
  always_ff @(posedge SYS_CLK) begin
    if (OBJ_WR && OBJ_INDEX == IDX_CTRL_ONE) begin
      last_c1 <= OBJ_WDATA[7:0] & C1_SAVED_BITS;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // Steps of the watched transfers
  sequence quiet_s;
    $past(RST_B) && $stable({OVERLOAD_POS, OVERLOAD_NEG, GROSS_ABOVE_LIMIT,
      GROSS_BELOW_LIMIT, inv, PARAMS_DIFFER});
  endsequence
  sequence bad_zero_s;
    OBJ_WR && OBJ_INDEX == IDX_ZERO_TRIG && OBJ_WDATA != MAGIC_ZERO;
  endsequence
  sequence c1_write_s;
    OBJ_WR && OBJ_INDEX == IDX_CTRL_ONE ##1 !OBJ_WR;
  endsequence
  st_invalid_a: assert property (rd_st and quiet_s |=> OBJ_RDATA[0] == $past(inv))
    else $error("invalid flag wrong");
  st_pos_a: assert property (rd_st and quiet_s |=> OBJ_RDATA[1] ==
    $past(OVERLOAD_POS | GROSS_ABOVE_LIMIT)) else $error("positive flag wrong");
  st_neg_a: assert property (rd_st and quiet_s |=> OBJ_RDATA[2] ==
    $past(OVERLOAD_NEG | GROSS_BELOW_LIMIT)) else $error("negative flag wrong");
  param_match_a: assert property ((OBJ_RD && OBJ_INDEX == IDX_PARAM_MATCH) and quiet_s
    |=> OBJ_RDATA == {31'h0, $past(PARAMS_DIFFER)}) else $error("match flag wrong");
  wrong_magic_a: assert property (bad_zero_s |=> OBJ_ACK && !OBJ_ERR)
    else $error("wrong trigger value refused");
  trig_read_err_a: assert property (OBJ_RD && (OBJ_INDEX == IDX_CAL_TRIG ||
    OBJ_INDEX == IDX_ZERO_TRIG || OBJ_INDEX == IDX_TARE_TRIG) |=> OBJ_ACK && OBJ_ERR)
    else $error("trigger read not refused");
  saved_bits_a: assert property (c1_write_s |=> SAVED_CTRL_ONE == last_c1)
    else $error("saved control bits wrong");
  saved_clean_a: assert property ((SAVED_CTRL_ONE & 8'h33) == 8'h00)
    else $error("unsaved bit kept");
  peak_prio_a: assert property ((PEAK_FOLLOW & (PEAK_CLEAR | PEAK_HOLD)) == 2'h0)
    else $error("peak priority broken");
  clear_once_a: assert property (PEAK_CLEAR != 2'h0 |=> PEAK_CLEAR == 2'h0)
    else $error("one-off clear repeated");
endmodule : acs_checker

bind acs_top acs_checker chk (.SYS_CLK, .RST_B, .OBJ_INDEX, .OBJ_WR, .OBJ_RD, .OBJ_WDATA,
  .OBJ_RDATA, .OBJ_ACK, .OBJ_ERR, .OVERLOAD_POS, .OVERLOAD_NEG, .GROSS_ABOVE_LIMIT,
  .GROSS_BELOW_LIMIT, .WIRING_FAULT, .EXCITATION_UNDEF, .SCALING_ERR, .SHEET_ALWAYS_USE,
  .SHEET_PRESENT, .PARAMS_DIFFER, .PEAK_FOLLOW, .PEAK_CLEAR, .PEAK_HOLD, .SAVED_CTRL_ONE);

// ### verif/acs_core_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Amplifier core stand-in: ends each action after a set delay
// ------------------------------------------------------------
module acs_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [3:0] dly,
  output logic done
);
  logic run;
  logic [3:0] cnt;
  // Count down from each start, then pulse done once
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (!rst_b) begin
      run <= 1'b0;
      cnt <= 4'h0;
    end else if (start) begin
      run <= 1'b1;
      cnt <= dly;
    end else if (run && cnt == 4'h0) begin
      run <= 1'b0;
      done <= 1'b1;
    end else if (run) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : acs_core_model

// ### verif/tb.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Testbench for the control and status objects
// ------------------------------------------------------------
module tb;
  import acs_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [15:0] OBJ_INDEX = 16'h0000;
  logic OBJ_WR = 1'b0;
  logic OBJ_RD = 1'b0;
  logic [31:0] OBJ_WDATA = 32'h00000000;
  logic [10:0] cond = 11'h000;
  logic [3:0] dly = 4'h2;
  logic [31:0] OBJ_RDATA;
  logic OBJ_ACK;
  logic OBJ_ERR;
  logic ACTION_DONE;
  logic ACTION_START;
  acs_code_t ACTION_CODE;
  logic [1:0] PEAK_FOLLOW;
  logic [1:0] PEAK_CLEAR;
  logic [1:0] PEAK_HOLD;
  logic [7:0] SAVED_CTRL_ONE;
  logic [31:0] v;
  int n_fail = 0;
  int check_count = 0;
  int clears = 0;
  acs_code_t codes[$];
  acs_top dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .OBJ_INDEX(OBJ_INDEX), .OBJ_WR(OBJ_WR),
    .OBJ_RD(OBJ_RD), .OBJ_WDATA(OBJ_WDATA), .OBJ_RDATA(OBJ_RDATA), .OBJ_ACK(OBJ_ACK),
    .OBJ_ERR(OBJ_ERR), .OVERLOAD_POS(cond[0]), .OVERLOAD_NEG(cond[1]),
    .GROSS_ABOVE_LIMIT(cond[2]), .GROSS_BELOW_LIMIT(cond[3]), .WIRING_FAULT(cond[4]),
    .EXCITATION_UNDEF(cond[5]), .SCALING_ERR(cond[6]), .SHEET_ALWAYS_USE(cond[7]),
    .SHEET_PRESENT(cond[8]), .PARAMS_DIFFER(cond[9]), .SYNC_MASTER_PIN(cond[10]),
    .ACTION_DONE(ACTION_DONE), .ACTION_START(ACTION_START), .ACTION_CODE(ACTION_CODE),
    .PEAK_FOLLOW(PEAK_FOLLOW), .PEAK_CLEAR(PEAK_CLEAR), .PEAK_HOLD(PEAK_HOLD),
    .SAVED_CTRL_ONE(SAVED_CTRL_ONE));
  acs_core_model core (.clk(SYS_CLK), .rst_b(RST_B), .start(ACTION_START), .dly(dly),
    .done(ACTION_DONE));
  // Clock and run limit
  initial forever #4 SYS_CLK = ~SYS_CLK;
  initial begin
    repeat (90000) @(posedge SYS_CLK);
    n_fail++;
    tally_and_finish();
  end
  // Log started actions and one-off clears on PEAK_CLEAR bit 0
  always @(posedge SYS_CLK) begin
    if (ACTION_START === 1'b1) codes.push_back(ACTION_CODE);
    if (PEAK_CLEAR[0] === 1'b1) clears++;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] d,
    input logic err);
    @(posedge SYS_CLK);
    #1;
    OBJ_INDEX = idx;
    OBJ_WDATA = d;
    OBJ_WR = wr;
    OBJ_RD = !wr;
    @(posedge SYS_CLK);
    #1;
    OBJ_WR = 1'b0;
    OBJ_RD = 1'b0;
    v = OBJ_RDATA;
    check("ack and err", {30'h0, OBJ_ACK, OBJ_ERR}, {30'h0, 1'b1, err});
  endtask : access
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    access(1'b1, idx, d, 1'b0);
  endtask : wr
  task automatic expect_codes(input string what, input int n, input logic [7:0] exp);
    int i;
    for (i = 0; i < 400 && codes.size() < n; i++) @(posedge SYS_CLK);
    if (i == 400) begin
      n_fail++;
      tally_and_finish();
    end
    repeat (40) @(posedge SYS_CLK);
    check(what, 32'(codes.size()), 32'(n));
    for (i = 0; i < n && i < codes.size(); i++) check(what, codes[i], exp[2*i +: 2]);
    codes.delete();
  endtask : expect_codes
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_regs();
    logic [15:0] idx[6] = '{IDX_CTRL_ONE, IDX_CTRL_ONE_MASK, IDX_CTRL_TWO,
      IDX_CTRL_TWO_MASK, IDX_PROF_CTRL, IDX_PROF_MASK};
    foreach (idx[i]) begin
      access(1'b0, idx[i], 32'h0, 1'b0);
      check("reset value", v, 32'h0);
    end
    cond[10] = 1'b1;
    repeat (8) @(posedge SYS_CLK);
    access(1'b0, IDX_SYNC_ROLE, 32'h0, 1'b0);
    check("sync role", v, 32'h1);
    access(1'b0, 16'h1234, 32'h0, 1'b1);
    access(1'b1, IDX_MEAS_STATUS, 32'h0, 1'b1);
    // Life counter returns its old value and counts each read
    access(1'b0, IDX_LIFE_CNT, 32'h0, 1'b0);
    check("life counter first", v, 32'h0);
    access(1'b0, IDX_LIFE_CNT, 32'h0, 1'b0);
    check("life counter next", v, 32'h1);
  endtask : t_reset_regs
  task automatic t_status();
    logic [9:0] tbl[12] = '{10'h001, 10'h004, 10'h002, 10'h008, 10'h010, 10'h020,
      10'h040, 10'h080, 10'h180, 10'h100, 10'h200, 10'h000};
    logic [2:0] e;
    foreach (tbl[i]) begin
      @(posedge SYS_CLK);
      #1;
      cond[9:0] = tbl[i];
      repeat (3) @(posedge SYS_CLK);
      e[0] = |(tbl[i] & 10'h073) | (tbl[i][7] & !tbl[i][8]);
      e[1] = tbl[i][0] | tbl[i][2];
      e[2] = tbl[i][1] | tbl[i][3];
      access(1'b0, IDX_MEAS_STATUS, 32'h0, 1'b0);
      check("status", v & 32'h7, {29'h0, e});
      access(1'b0, IDX_PARAM_MATCH, 32'h0, 1'b0);
      check("match flag", v, {31'h0, tbl[i][9]});
    end
  endtask : t_status
  task automatic t_triggers();
    wr(IDX_ZERO_TRIG, MAGIC_TARE);
    expect_codes("wrong value", 0, 8'h00);
    dly = 4'hF;
    wr(IDX_ZERO_TRIG, MAGIC_ZERO);
    wr(IDX_TARE_TRIG, MAGIC_TARE);
    wr(IDX_CAL_TRIG, MAGIC_CAL);
    expect_codes("triggers", 3, 8'h24);
    access(1'b0, IDX_CAL_TRIG, 32'h0, 1'b1);
    dly = 4'h2;
  endtask : t_triggers
  task automatic t_profile();
    wr(IDX_PROF_CTRL, 32'h07);
    expect_codes("profile masked", 0, 8'h00);
    wr(IDX_PROF_CTRL, 32'h00);
    wr(IDX_PROF_MASK, 32'h07);
    wr(IDX_PROF_CTRL, 32'h07);
    expect_codes("profile order", 3, 8'h24);
    wr(IDX_PROF_CTRL, 32'h00);
  endtask : t_profile
  task automatic t_ctrl_two();
    wr(IDX_CTRL_TWO_MASK, 32'h02);
    wr(IDX_CTRL_TWO, 32'h06);
    expect_codes("byte two mask", 1, 8'h00);
    wr(IDX_CTRL_TWO, 32'h00);
    wr(IDX_CTRL_TWO_MASK, 32'hFF);
    wr(IDX_CTRL_TWO, 32'h06);
    expect_codes("byte two order", 2, 8'h04);
    wr(IDX_CTRL_TWO, 32'h00);
    wr(IDX_CTRL_TWO, 32'h80); // Sheet bit alone
    expect_codes("sheet calibration", 1, 8'h03);
    wr(IDX_CTRL_TWO, 32'h00);
  endtask : t_ctrl_two
  task automatic t_ctrl_one();
    wr(IDX_CTRL_ONE_MASK, 32'hFF);
    wr(IDX_CTRL_ONE, 32'h03);
    expect_codes("byte one order", 2, 8'h04);
    wr(IDX_CTRL_ONE, 32'h03);
    expect_codes("held level", 0, 8'h00);
    wr(IDX_CTRL_ONE, 32'h00);
    wr(IDX_CTRL_ONE, 32'h10);
    repeat (10) @(posedge SYS_CLK);
    check("one-off clears", 32'(clears), 32'h1);
    access(1'b0, IDX_CTRL_ONE, 32'h0, 1'b0);
    check("one-off readback", v & 32'h10, 32'h0);
    // One-off clear behind zeroing and taring stays pending and reads 1
    wr(IDX_CTRL_ONE, 32'h13);
    access(1'b0, IDX_CTRL_ONE, 32'h0, 1'b0);
    check("one-off pending", v & 32'h10, 32'h10);
    repeat (2) @(posedge SYS_CLK);
    check("clear waits", 32'(clears), 32'h1);
    expect_codes("byte one with peak", 2, 8'h04);
    check("clear after actions", 32'(clears), 32'h2);
    wr(IDX_CTRL_ONE, 32'h04);
    repeat (3) @(posedge SYS_CLK);
    check("follow", {30'h0, PEAK_FOLLOW}, 32'h1);
    check("saved", {24'h0, SAVED_CTRL_ONE}, 32'h04);
    wr(IDX_CTRL_ONE, 32'h44);
    repeat (3) @(posedge SYS_CLK);
    check("hold under follow", {30'h0, PEAK_HOLD}, 32'h0);
    wr(IDX_CTRL_ONE, 32'h40);
    repeat (3) @(posedge SYS_CLK);
    check("hold", {30'h0, PEAK_HOLD}, 32'h1);
    wr(IDX_CTRL_ONE, 32'h00);
    wr(IDX_CTRL_ONE_MASK, 32'h00);
    wr(IDX_CTRL_ONE, 32'h01);
    expect_codes("byte one masked", 0, 8'h00);
  endtask : t_ctrl_one
  // Main sequence
  initial begin
    repeat (16) @(posedge SYS_CLK);
    #1;
    RST_B = 1'b1;
    t_reset_regs();
    t_status();
    t_triggers();
    t_profile();
    t_ctrl_two();
    t_ctrl_one();
    tally_and_finish();
  end
endmodule : tb
